// ### acsi_top.sv
// serial interface top: apb registers, baud divider, buffers, pins, irq
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Operation
// - one start bit, one to eight data
// - optional even, odd or no parity
// - one or two stop bits
// - sixteen bit software baud divisor
// - asynchronous or isosynchronous mode select
// - top rates: clock/16 async, /2 iso
// - detect break, parity, overrun, framing errors
// - holding buffers, per-path enable and interrupt
// - transmitter and receiver run independently
// - idle-line and address-bit wake-up
// - transmit buffer free flag
// - transmit shift register empty flag
// - receive buffer full flag
// - break seen flag
// - combined receive error flag
// - separate tx/rx interrupt enables, break apart
// - nrz bits held whole period
// - clock output in iso mode, pins usable as gpio
module acsi_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic serial_tx_pin_in,
  output logic serial_tx_pin_out,
  output logic serial_tx_pin_oe_n,
  input wire logic serial_rx_pin_in,
  output logic serial_rx_pin_out,
  output logic serial_rx_pin_oe_n,
  input wire logic serial_bit_clock_pin_in,
  output logic serial_bit_clock_pin_out,
  output logic serial_bit_clock_pin_oe_n
);
  // ==========================================================
  // declarations
  logic [15:0] ctrl, next_ctrl, baud, next_baud, bcnt, next_bcnt;
  logic [7:0] txbuf, next_txbuf, rxbuf, next_rxbuf;
  logic txbuf_full, next_txbuf_full, txbuf_addr, next_txbuf_addr;
  logic rx_full, next_rx_full, rxbuf_addr, next_rxbuf_addr;
  logic pe, next_pe, fe, next_fe, ovr, next_ovr, brk, next_brk;
  logic [3:0] istat, next_istat, mask, next_mask, ev;
  logic [2:0] gdir, next_gdir, gout, next_gout, gin;
  logic [31:0] next_prdata, wv, rv;
  logic sclk, next_sclk;
  logic [2:0] next_pin_out, next_pin_oe_n;
  logic wr_now, rd_now, tick, tx_load, tx_busy, tx_line;
  logic rx_done, rx_perr, rx_ferr, rx_brk, rx_ab, rx_gap, rx_line;
  logic [7:0] rx_data;
  logic wake, is_addr, accept, iso, pin_fn;
  logic tx_buffer_free_flag, tx_empty_flag;
  logic rx_buffer_full_flag, break_seen_flag, rx_error_flag;
  logic [4:0] os;

  // ==========================================================
  // helpers
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    case (a)
      acsi_pkg::ADDR_CTRL, acsi_pkg::ADDR_BAUD, acsi_pkg::ADDR_TXDATA,
      acsi_pkg::ADDR_RXDATA, acsi_pkg::ADDR_STATUS, acsi_pkg::ADDR_IRQ_STAT,
      acsi_pkg::ADDR_IRQ_MASK, acsi_pkg::ADDR_GPIO_DIR,
      acsi_pkg::ADDR_GPIO_OUT, acsi_pkg::ADDR_GPIO_IN: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // ==========================================================
  // apb handshake, zero wait states
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped(paddr);
  assign wr_now = psel && penable && pwrite && mapped(paddr);
  assign rd_now = psel && penable && !pwrite && mapped(paddr);

  // ==========================================================
  // mode decode and flags
  assign iso = ctrl[acsi_pkg::CTRL_ISO];
  // async samples 16 times per bit, iso twice
  assign os = iso ? acsi_pkg::OS_ISO : acsi_pkg::OS_ASYNC;
  assign pin_fn = ctrl[acsi_pkg::CTRL_PIN_FN];
  assign wake = ctrl[acsi_pkg::CTRL_WAKE_EN];
  assign tx_buffer_free_flag = !txbuf_full;
  assign tx_empty_flag = !tx_busy;
  assign rx_buffer_full_flag = rx_full;
  assign break_seen_flag = brk;
  assign rx_error_flag = pe | fe | ovr | brk;
  assign gin = {serial_bit_clock_pin_in, serial_rx_pin_in,
    serial_tx_pin_in};
  assign rx_line = pin_fn ? serial_rx_pin_in : 1'b1;
  // idle shifter takes the held char on a tick: start bit is whole
  assign tx_load = txbuf_full && !tx_busy
    && ctrl[acsi_pkg::CTRL_TX_EN] && tick;
  // address char: gap before it, or address bit set
  assign is_addr = wake && (ctrl[acsi_pkg::CTRL_WAKE_ADDR] ? rx_ab
    : rx_gap);
  assign accept = rx_done && (!ctrl[acsi_pkg::CTRL_SLEEP] || is_addr);
  assign irq = |(istat & mask);

  // ==========================================================
  // baud divider
  assign tick = (bcnt == 16'h0000);

  always_comb begin
    next_bcnt = tick ? baud : bcnt - 16'h0001;
    next_sclk = 1'b1;
    // iso clock toggles each tick while shifting out
    if (iso && tx_busy) begin
      next_sclk = tick ? ~sclk : sclk;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt <= 16'h0000;
      sclk <= 1'b1;
    end else begin
      bcnt <= next_bcnt;
      sclk <= next_sclk;
    end
  end

  // ==========================================================
  // shifters
  acsi_tx u_tx (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .os(os),
    .len(ctrl[acsi_pkg::CTRL_LEN_LSB +: 3]),
    .par_en(ctrl[acsi_pkg::CTRL_PAR_EN]),
    .par_odd(ctrl[acsi_pkg::CTRL_PAR_ODD]),
    .two_stop(ctrl[acsi_pkg::CTRL_STOP2]),
    .addr_mode(wake && ctrl[acsi_pkg::CTRL_WAKE_ADDR]),
    .load(tx_load),
    .load_data(txbuf),
    .load_addr(txbuf_addr),
    .load_gap(wake && !ctrl[acsi_pkg::CTRL_WAKE_ADDR] && txbuf_addr),
    .busy(tx_busy),
    .line(tx_line)
  );

  acsi_rx u_rx (
    .pclk(pclk),
    .presetn(presetn),
    .en(ctrl[acsi_pkg::CTRL_RX_EN]),
    .tick(tick),
    .os(os),
    .len(ctrl[acsi_pkg::CTRL_LEN_LSB +: 3]),
    .par_en(ctrl[acsi_pkg::CTRL_PAR_EN]),
    .par_odd(ctrl[acsi_pkg::CTRL_PAR_ODD]),
    .two_stop(ctrl[acsi_pkg::CTRL_STOP2]),
    .addr_mode(wake && ctrl[acsi_pkg::CTRL_WAKE_ADDR]),
    .line(rx_line),
    .done(rx_done),
    .data(rx_data),
    .perr(rx_perr),
    .ferr(rx_ferr),
    .brk(rx_brk),
    .addr_bit(rx_ab),
    .gap(rx_gap)
  );

  // ==========================================================
  // register file, buffers and event flags
  always_comb begin
    next_ctrl = ctrl;
    next_baud = baud;
    next_txbuf = txbuf;
    next_txbuf_full = txbuf_full;
    next_txbuf_addr = txbuf_addr;
    next_rxbuf = rxbuf;
    next_rx_full = rx_full;
    next_rxbuf_addr = rxbuf_addr;
    {next_pe, next_fe, next_ovr, next_brk} = {pe, fe, ovr, brk};
    next_istat = istat;
    next_mask = mask;
    next_gdir = gdir;
    next_gout = gout;
    wv = 32'h0000_0000;
    ev = 4'h0;
    if (tx_load) begin
      next_txbuf_full = 1'b0;
      ev[acsi_pkg::IRQ_TX] = ctrl[acsi_pkg::CTRL_TX_IE];
    end
    if (wr_now) begin
      case (paddr)
        acsi_pkg::ADDR_CTRL: begin
          wv = merge({16'h0000, ctrl}, pwdata, pstrb);
          next_ctrl = wv[15:0];
        end
        acsi_pkg::ADDR_BAUD: begin
          wv = merge({16'h0000, baud}, pwdata, pstrb);
          next_baud = wv[15:0];
        end
        acsi_pkg::ADDR_TXDATA: if (pstrb[0] && !txbuf_full) begin
          next_txbuf = pwdata[7:0];
          next_txbuf_addr = pwdata[8];
          next_txbuf_full = 1'b1;
        end
        acsi_pkg::ADDR_IRQ_MASK: if (pstrb[0]) next_mask = pwdata[3:0];
        acsi_pkg::ADDR_GPIO_DIR: if (pstrb[0]) next_gdir = pwdata[2:0];
        acsi_pkg::ADDR_GPIO_OUT: if (pstrb[0]) next_gout = pwdata[2:0];
        default: ;
      endcase
    end
    // read side effects; hardware sets below win
    if (rd_now && paddr == acsi_pkg::ADDR_RXDATA) begin
      next_rx_full = 1'b0;
      {next_pe, next_fe, next_ovr, next_brk} = 4'h0;
    end
    if (rd_now && paddr == acsi_pkg::ADDR_IRQ_STAT) begin
      next_istat = istat & ~prdata[3:0];
    end
    if (rx_done && rx_brk) begin
      next_brk = 1'b1;
      ev[acsi_pkg::IRQ_BRK] = 1'b1;
    end
    if (accept) begin
      if (next_rx_full) begin
        next_ovr = 1'b1;
      end else begin
        next_rxbuf = rx_data;
        next_rxbuf_addr = is_addr;
        next_rx_full = 1'b1;
      end
      next_pe = next_pe | rx_perr;
      next_fe = next_fe | rx_ferr;
      ev[acsi_pkg::IRQ_RX] = ctrl[acsi_pkg::CTRL_RX_IE];
      ev[acsi_pkg::IRQ_ERR] = ctrl[acsi_pkg::CTRL_RX_IE]
        && (rx_perr || rx_ferr || next_ovr);
    end
    next_istat = next_istat | ev;
  end

  // ==========================================================
  // read data, captured in the setup cycle
  always_comb begin
    rv = 32'h0000_0000;
    case (paddr)
      acsi_pkg::ADDR_CTRL: rv[15:0] = ctrl;
      acsi_pkg::ADDR_BAUD: rv[15:0] = baud;
      acsi_pkg::ADDR_TXDATA: rv[8:0] = {txbuf_addr, txbuf};
      acsi_pkg::ADDR_RXDATA: rv[8:0] = {rxbuf_addr, rxbuf};
      acsi_pkg::ADDR_STATUS: rv[7:0] = {fe, ovr, pe, rx_error_flag,
        break_seen_flag, rx_buffer_full_flag, tx_empty_flag,
        tx_buffer_free_flag};
      acsi_pkg::ADDR_IRQ_STAT: rv[3:0] = istat;
      acsi_pkg::ADDR_IRQ_MASK: rv[3:0] = mask;
      acsi_pkg::ADDR_GPIO_DIR: rv[2:0] = gdir;
      acsi_pkg::ADDR_GPIO_OUT: rv[2:0] = gout;
      acsi_pkg::ADDR_GPIO_IN: rv[2:0] = gin;
      default: ;
    endcase
    next_prdata = (psel && !penable && !pwrite) ? rv : prdata;
  end

  // ==========================================================
  // pin muxing: serial function or gpio
  always_comb begin
    next_pin_out = gout;
    next_pin_oe_n = ~gdir;
    if (pin_fn) begin
      next_pin_out[0] = tx_line;
      next_pin_oe_n[0] = 1'b0;
      next_pin_out[1] = 1'b1;
      next_pin_oe_n[1] = 1'b1;
      // clock pin drives only in iso mode when chosen
      next_pin_out[2] = sclk;
      next_pin_oe_n[2] = !(iso && ctrl[acsi_pkg::CTRL_CLK_OUT]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= acsi_pkg::CTRL_RESET;
      baud <= acsi_pkg::BAUD_RESET;
      txbuf <= 8'h00;
      {txbuf_full, txbuf_addr, rx_full, rxbuf_addr} <= 4'h0;
      rxbuf <= 8'h00;
      {pe, fe, ovr, brk} <= 4'h0;
      istat <= 4'h0;
      mask <= 4'h0;
      gdir <= 3'h0;
      gout <= 3'h0;
      prdata <= 32'h0000_0000;
      {serial_bit_clock_pin_out, serial_rx_pin_out,
        serial_tx_pin_out} <= 3'h7;
      {serial_bit_clock_pin_oe_n, serial_rx_pin_oe_n,
        serial_tx_pin_oe_n} <= 3'h7;
    end else begin
      ctrl <= next_ctrl;
      baud <= next_baud;
      txbuf <= next_txbuf;
      {txbuf_full, txbuf_addr} <= {next_txbuf_full, next_txbuf_addr};
      {rx_full, rxbuf_addr} <= {next_rx_full, next_rxbuf_addr};
      rxbuf <= next_rxbuf;
      {pe, fe, ovr, brk} <= {next_pe, next_fe, next_ovr, next_brk};
      istat <= next_istat;
      mask <= next_mask;
      gdir <= next_gdir;
      gout <= next_gout;
      prdata <= next_prdata;
      {serial_bit_clock_pin_out, serial_rx_pin_out,
        serial_tx_pin_out} <= next_pin_out;
      {serial_bit_clock_pin_oe_n, serial_rx_pin_oe_n,
        serial_tx_pin_oe_n} <= next_pin_oe_n;
    end
  end
endmodule

// ### acsi_pkg.sv
// package: register map, control fields, timing counts and frame states
package acsi_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BAUD = 8'h04;
  localparam logic [7:0] ADDR_TXDATA = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;
  localparam logic [7:0] ADDR_GPIO_DIR = 8'h1C;
  localparam logic [7:0] ADDR_GPIO_OUT = 8'h20;
  localparam logic [7:0] ADDR_GPIO_IN = 8'h24;
  // ==========================================================
  // control register fields
  localparam int CTRL_LEN_LSB = 0;
  localparam int CTRL_PAR_EN = 3;
  localparam int CTRL_PAR_ODD = 4;
  localparam int CTRL_STOP2 = 5;
  localparam int CTRL_ISO = 6;
  localparam int CTRL_TX_EN = 7;
  localparam int CTRL_RX_EN = 8;
  localparam int CTRL_TX_IE = 9;
  localparam int CTRL_RX_IE = 10;
  localparam int CTRL_WAKE_EN = 11;
  localparam int CTRL_WAKE_ADDR = 12;
  localparam int CTRL_SLEEP = 13;
  localparam int CTRL_CLK_OUT = 14;
  localparam int CTRL_PIN_FN = 15;
  // ==========================================================
  // interrupt status bits
  localparam int IRQ_TX = 0;
  localparam int IRQ_RX = 1;
  localparam int IRQ_ERR = 2;
  localparam int IRQ_BRK = 3;
  // ==========================================================
  // reset values and counts
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] BAUD_RESET = 16'h0001;
  localparam logic [4:0] OS_ASYNC = 5'h10;
  localparam logic [4:0] OS_ISO = 5'h02;
  localparam logic [3:0] TX_GAP_BITS = 4'hB;
  localparam logic [3:0] RX_GAP_BITS = 4'hA;
  // ==========================================================
  // frame sequencer states
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_GAP = 7'h02,
    ST_START = 7'h04,
    ST_DATA = 7'h08,
    ST_ADDR = 7'h10,
    ST_PAR = 7'h20,
    ST_STOP = 7'h40
  } acsi_state_t;
endpackage

// ### acsi_tx.sv
// transmit shift register and frame sequencer
`timescale 1ns/1ps
module acsi_tx (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic [4:0] os,
  input wire logic [2:0] len,
  input wire logic par_en,
  input wire logic par_odd,
  input wire logic two_stop,
  input wire logic addr_mode,
  input wire logic load,
  input wire logic [7:0] load_data,
  input wire logic load_addr,
  input wire logic load_gap,
  output logic busy,
  output logic line
);
  acsi_pkg::acsi_state_t state, next_state;
  logic [4:0] cnt, next_cnt;
  logic [3:0] bitn, next_bitn;
  logic [7:0] sh, next_sh;
  logic par, next_par, addrb, next_addrb, next_line;
  logic bit_end;

  assign busy = (state != acsi_pkg::ST_IDLE);
  assign bit_end = tick && (cnt == os - 5'h01);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_bitn = bitn;
    next_sh = sh;
    next_par = par;
    next_addrb = addrb;
    if (tick) begin
      next_cnt = bit_end ? 5'h00 : cnt + 5'h01;
    end
    case (state)
      acsi_pkg::ST_IDLE: begin
        next_cnt = 5'h00;
        if (load) begin
          next_sh = load_data;
          next_addrb = load_addr;
          next_par = 1'b0;
          next_bitn = 4'h0;
          // idle-line wake: address char leads with a gap
          next_state = load_gap ? acsi_pkg::ST_GAP : acsi_pkg::ST_START;
        end
      end
      acsi_pkg::ST_GAP: if (bit_end) begin
        next_bitn = bitn + 4'h1;
        if (bitn == acsi_pkg::TX_GAP_BITS - 4'h1) begin
          next_bitn = 4'h0;
          next_state = acsi_pkg::ST_START;
        end
      end
      acsi_pkg::ST_START: if (bit_end) next_state = acsi_pkg::ST_DATA;
      acsi_pkg::ST_DATA: if (bit_end) begin
        next_sh = {1'b0, sh[7:1]};
        next_par = par ^ sh[0];
        next_bitn = bitn + 4'h1;
        if (bitn[2:0] == len) begin
          next_bitn = 4'h0;
          if (addr_mode) next_state = acsi_pkg::ST_ADDR;
          else if (par_en) next_state = acsi_pkg::ST_PAR;
          else next_state = acsi_pkg::ST_STOP;
        end
      end
      acsi_pkg::ST_ADDR: if (bit_end) begin
        next_state = par_en ? acsi_pkg::ST_PAR : acsi_pkg::ST_STOP;
      end
      acsi_pkg::ST_PAR: if (bit_end) next_state = acsi_pkg::ST_STOP;
      acsi_pkg::ST_STOP: if (bit_end) begin
        next_bitn = bitn + 4'h1;
        if (bitn[0] == two_stop) begin
          next_bitn = 4'h0;
          next_state = acsi_pkg::ST_IDLE;
        end
      end
      default: next_state = acsi_pkg::ST_IDLE;
    endcase
    // line level held for the whole bit
    case (next_state)
      acsi_pkg::ST_START: next_line = 1'b0;
      acsi_pkg::ST_DATA: next_line = next_sh[0];
      acsi_pkg::ST_ADDR: next_line = next_addrb;
      acsi_pkg::ST_PAR: next_line = next_par ^ par_odd;
      default: next_line = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= acsi_pkg::ST_IDLE;
      cnt <= 5'h00;
      bitn <= 4'h0;
      sh <= 8'h00;
      par <= 1'b0;
      addrb <= 1'b0;
      line <= 1'b1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      bitn <= next_bitn;
      sh <= next_sh;
      par <= next_par;
      addrb <= next_addrb;
      line <= next_line;
    end
  end
endmodule

// ### acsi_rx.sv
// receive shift register, frame checker and idle-gap detector
`timescale 1ns/1ps
module acsi_rx (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic tick,
  input wire logic [4:0] os,
  input wire logic [2:0] len,
  input wire logic par_en,
  input wire logic par_odd,
  input wire logic two_stop,
  input wire logic addr_mode,
  input wire logic line,
  output logic done,
  output logic [7:0] data,
  output logic perr,
  output logic ferr,
  output logic brk,
  output logic addr_bit,
  output logic gap
);
  acsi_pkg::acsi_state_t state, next_state;
  logic [4:0] cnt, next_cnt;
  logic [3:0] bitn, next_bitn, gapc, next_gapc;
  logic [7:0] sh, next_sh, next_data;
  logic par, next_par, pe, next_pe, fe, next_fe, zero, next_zero;
  logic ab, next_ab, gp, next_gp, armed, next_armed, next_done;
  logic bit_end;

  assign bit_end = tick && (cnt == os - 5'h01);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_bitn = bitn;
    next_gapc = gapc;
    next_sh = sh;
    next_par = par;
    next_pe = pe;
    next_fe = fe;
    next_zero = zero;
    next_ab = ab;
    next_gp = gp;
    next_armed = armed;
    next_done = 1'b0;
    next_data = data;
    case (state)
      acsi_pkg::ST_IDLE: if (!en) begin
        next_cnt = 5'h00;
      end else if (tick) begin
        if (!line && armed) begin
          next_state = acsi_pkg::ST_START;
          next_cnt = 5'h00;
          next_gp = (gapc == acsi_pkg::RX_GAP_BITS);
          next_gapc = 4'h0;
          next_bitn = 4'h0;
          {next_par, next_pe, next_fe, next_ab} = 4'h0;
          next_zero = 1'b1;
          next_armed = 1'b0;
        end else if (line) begin
          next_armed = 1'b1;
          next_cnt = bit_end ? 5'h00 : cnt + 5'h01;
          if (bit_end && gapc != acsi_pkg::RX_GAP_BITS) begin
            next_gapc = gapc + 4'h1;
          end
        end
      end
      acsi_pkg::ST_START: if (tick) begin
        // recheck the start bit at its middle
        next_cnt = cnt + 5'h01;
        if (cnt == (os >> 1) - 5'h01) begin
          next_cnt = 5'h00;
          next_state = line ? acsi_pkg::ST_IDLE : acsi_pkg::ST_DATA;
        end
      end
      acsi_pkg::ST_DATA, acsi_pkg::ST_ADDR, acsi_pkg::ST_PAR,
      acsi_pkg::ST_STOP: if (tick) begin
        next_cnt = bit_end ? 5'h00 : cnt + 5'h01;
        if (bit_end) begin
          if (state != acsi_pkg::ST_STOP || bitn == 4'h0) begin
            next_zero = zero & ~line;
          end
          if (state == acsi_pkg::ST_DATA) begin
            next_sh = {line, sh[7:1]};
            next_par = par ^ line;
            next_bitn = bitn + 4'h1;
            if (bitn[2:0] == len) begin
              next_bitn = 4'h0;
              if (addr_mode) next_state = acsi_pkg::ST_ADDR;
              else if (par_en) next_state = acsi_pkg::ST_PAR;
              else next_state = acsi_pkg::ST_STOP;
            end
          end else if (state == acsi_pkg::ST_ADDR) begin
            next_ab = line;
            next_state = par_en ? acsi_pkg::ST_PAR : acsi_pkg::ST_STOP;
          end else if (state == acsi_pkg::ST_PAR) begin
            next_pe = (par ^ par_odd) != line;
            next_state = acsi_pkg::ST_STOP;
          end else begin
            next_fe = fe | ~line;
            next_bitn = bitn + 4'h1;
            if (bitn[0] == two_stop) begin
              next_state = acsi_pkg::ST_IDLE;
              next_done = 1'b1;
              next_data = sh >> (3'h7 - len);
            end
          end
        end
      end
      default: next_state = acsi_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= acsi_pkg::ST_IDLE;
      cnt <= 5'h00;
      bitn <= 4'h0;
      gapc <= acsi_pkg::RX_GAP_BITS;
      sh <= 8'h00;
      {par, pe, fe, ab, gp, armed, done} <= 7'h00;
      zero <= 1'b0;
      data <= 8'h00;
      {perr, ferr, brk, addr_bit, gap} <= 5'h00;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      bitn <= next_bitn;
      gapc <= next_gapc;
      sh <= next_sh;
      {par, pe, fe, ab, gp, armed} <= {next_par, next_pe, next_fe, next_ab,
        next_gp, next_armed};
      zero <= next_zero;
      done <= next_done;
      data <= next_data;
      if (next_done) begin
        {perr, ferr, brk, addr_bit, gap} <= {next_pe, next_fe, next_zero,
          next_ab, next_gp};
      end
    end
  end
endmodule

// ### acsi_chk.sv
// checker: apb answers, pin release and transmit bit timing
`timescale 1ns/1ps
module acsi_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic serial_tx_pin_out,
  input wire logic serial_tx_pin_oe_n,
  input wire logic serial_rx_pin_oe_n,
  input wire logic serial_bit_clock_pin_oe_n
);
  logic acc, setup, unmap, prev_tx;
  logic [7:0] run, next_run;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign acc = psel && penable;
  assign setup = psel && !penable;
  assign unmap = paddr[1:0] != 2'h0 || paddr > acsi_pkg::ADDR_GPIO_IN;
  // cycles since the tx pin last changed, saturating
  always_comb begin
    next_run = (serial_tx_pin_out != prev_tx) ? 8'h00 : run + 8'h01;
    if (run == 8'hFF && serial_tx_pin_out == prev_tx) next_run = run;
    if (serial_tx_pin_oe_n) next_run = 8'hFF;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_tx <= 1'b1;
      run <= 8'h00;
    end else begin
      prev_tx <= serial_tx_pin_oe_n ? 1'b1 : serial_tx_pin_out;
      run <= next_run;
    end
  end
  sequence s_low8;
    !serial_tx_pin_out [*8];
  endsequence
  a_ready_const: assert property (pready)
    else $error("pready low");
  a_err_unmapped: assert property (acc && unmap |->
    pslverr && prdata == 0)
    else $error("unmapped access not refused");
  a_err_mapped: assert property (acc && !unmap |-> !pslverr)
    else $error("mapped access refused");
  a_err_idle: assert property (!acc |-> !pslverr)
    else $error("error outside access");
  a_rdata_hold: assert property ($changed(prdata) |-> $past(setup))
    else $error("read data moved without setup");
  a_pins_free: assert property ($rose(presetn) |->
    serial_tx_pin_oe_n && serial_rx_pin_oe_n && serial_bit_clock_pin_oe_n)
    else $error("pin driven after reset");
  a_nrz_hold: assert property ($changed(serial_tx_pin_out) &&
    !serial_tx_pin_oe_n |-> run >= 8'h1F)
    else $error("tx bit shorter than a bit time");
  a_start_hold: assert property ($fell(serial_tx_pin_out) &&
    !serial_tx_pin_oe_n |-> s_low8)
    else $error("start bit too short");
endmodule
bind acsi_top acsi_chk u_chk (.pclk, .presetn, .psel, .penable, .paddr,
  .prdata, .pready, .pslverr, .serial_tx_pin_out, .serial_tx_pin_oe_n,
  .serial_rx_pin_oe_n, .serial_bit_clock_pin_oe_n);

// ### acsi_peer.sv
// far-side serial peer: frame sender and receiver
`timescale 1ns/1ps
module acsi_peer #(parameter int BIT = 32) (
  input wire logic pclk,
  input wire logic tx_line,
  output logic rx_line
);
  initial rx_line = 1'b1;
  task automatic send(input logic [10:0] bits, input int n);
    rx_line <= 1'b0;
    repeat (BIT) @(posedge pclk);
    for (int i = 0; i < n; i++) begin
      rx_line <= bits[i];
      repeat (BIT) @(posedge pclk);
    end
    rx_line <= 1'b1;
    @(posedge pclk);
  endtask
  task automatic recv(output logic [8:0] got, output logic ok);
    int w;
    w = 0;
    while (tx_line && w < 4000) begin
      @(negedge pclk);
      w++;
    end
    repeat (BIT / 2) @(negedge pclk);
    ok = !tx_line;
    for (int i = 0; i < 9; i++) begin
      repeat (BIT) @(negedge pclk);
      got[i] = tx_line;
    end
  endtask
endmodule

// ### acsi_tb.sv
// testbench: registers, transmit, receive and receive errors
`timescale 1ns/1ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err, ok;
  logic [7:0] paddr;
  logic [8:0] got;
  logic [31:0] pwdata, prdata, rd;
  logic tx_o, tx_oen, rx_o, rx_oen, ck_o, ck_oen, peer_rx, tx_w, rx_w, ck_w;
  int n_fail, checks;
  assign tx_w = tx_oen ? 1'b1 : tx_o;
  assign rx_w = rx_oen ? peer_rx : rx_o;
  assign ck_w = ck_oen ? 1'b1 : ck_o;
  acsi_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr, .irq,
    .serial_tx_pin_in(tx_w), .serial_tx_pin_out(tx_o),
    .serial_tx_pin_oe_n(tx_oen), .serial_rx_pin_in(rx_w),
    .serial_rx_pin_out(rx_o), .serial_rx_pin_oe_n(rx_oen),
    .serial_bit_clock_pin_in(ck_w), .serial_bit_clock_pin_out(ck_o),
    .serial_bit_clock_pin_oe_n(ck_oen));
  acsi_peer u_peer (.pclk, .tx_line(tx_w), .rx_line(peer_rx));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    err = pslverr;
    chk(pready, 16'h0001);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_reset();
    apb(0, acsi_pkg::ADDR_CTRL, 0);
    chk(rd[15:0], acsi_pkg::CTRL_RESET);
    apb(0, acsi_pkg::ADDR_BAUD, 0);
    chk(rd[15:0], acsi_pkg::BAUD_RESET);
    apb(0, acsi_pkg::ADDR_STATUS, 0);
    chk(rd[15:0], 16'h0003);
    apb(0, 8'h28, 0);
    chk({rd[14:0], err}, 16'h0001);
    $display("test reset done");
  endtask
  task automatic t_tx();
    apb(1, acsi_pkg::ADDR_IRQ_MASK, 16'h000F);
    apb(1, acsi_pkg::ADDR_CTRL, 16'h8787);
    apb(1, acsi_pkg::ADDR_TXDATA, 16'h00A5);
    apb(1, acsi_pkg::ADDR_TXDATA, 16'h003C);
    apb(0, acsi_pkg::ADDR_STATUS, 0);
    chk(rd[1:0], 16'h0000);
    u_peer.recv(got, ok);
    chk({ok, got}, 16'h03A5);
    u_peer.recv(got, ok);
    chk({ok, got}, 16'h033C);
    repeat (20) @(posedge pclk);
    chk(irq, 16'h0001);
    apb(0, acsi_pkg::ADDR_STATUS, 0);
    chk(rd[15:0], 16'h0003);
    apb(0, acsi_pkg::ADDR_IRQ_STAT, 0);
    @(posedge pclk);
    chk(irq, 16'h0000);
    $display("test tx done");
  endtask
  task automatic rx(input logic [10:0] b, input int n, input logic [15:0] s);
    u_peer.send(b, n);
    repeat (4) @(posedge pclk);
    apb(0, acsi_pkg::ADDR_STATUS, 0);
    chk(rd[15:0], s);
  endtask
  task automatic t_rx();
    rx(11'h13C, 9, 16'h0007);
    chk(irq, 16'h0001);
    apb(0, acsi_pkg::ADDR_RXDATA, 0);
    chk(rd[15:0], 16'h003C);
    u_peer.send(11'h111, 9);
    rx(11'h122, 9, 16'h0057);
    apb(0, acsi_pkg::ADDR_RXDATA, 0);
    chk(rd[15:0], 16'h0011);
    rx(11'h000, 9, 16'h009F);
    chk(irq, 16'h0001);
    apb(0, acsi_pkg::ADDR_RXDATA, 0);
    apb(1, acsi_pkg::ADDR_CTRL, 16'h878F);
    rx(11'h201, 10, 16'h0037);
    apb(0, acsi_pkg::ADDR_RXDATA, 0);
    apb(1, acsi_pkg::ADDR_CTRL, 16'h879F);
    rx(11'h201, 10, 16'h0007);
    $display("test rx done");
  endtask
  task automatic summarize();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    n_fail = 0;
    checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_tx();
    t_rx();
    summarize();
  end
  initial begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    summarize();
  end
endmodule
